/* dio_consts.svh */
// register offsets, reset values and field constants for the dual port block
`ifndef DIO_CONSTS_SVH
`define DIO_CONSTS_SVH
`define DIO_ADDR_W          20
`define DIO_OFF_TWO_DIR     20'hee001
`define DIO_OFF_TWO_PULLUP  20'hee03c
`define DIO_OFF_TWO_LATCH   20'hfffd1
`define DIO_OFF_EIGHT_DIR   20'hee007
`define DIO_OFF_EIGHT_LATCH 20'hfffd7
`define DIO_RST_TWO_DIR_EXP 8'hff
`define DIO_RST_TWO_DIR_SC  8'h00
`define DIO_RST_TWO_LATCH   8'h00
`define DIO_RST_TWO_PULLUP  8'h00
`define DIO_RST_EIGHT_DIR_EXP 8'hf0
`define DIO_RST_EIGHT_DIR_SC  8'he0
`define DIO_RST_EIGHT_LATCH 8'he0
`define DIO_EIGHT_RSV_MASK  8'he0
`define DIO_ALL_ONES        8'hff
`define DIO_MODE_W          3
`endif

/* dio_pkg.sv */
// types for the dual port block
package dio_pkg;
  typedef enum logic [1:0] {
    DIO_GRP_EXP_NOROM,
    DIO_GRP_EXP_ROM,
    DIO_GRP_SINGLE,
    DIO_GRP_INVALID
  } dio_mode_grp_t;
endpackage

/* dio_port.sv */
// two 8-bit general purpose ports with mode dependent direction handling
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ns
`include "dio_consts.svh"
module dio_port
  import dio_pkg::*;
(
  // clock and reset
  input  wire logic                   i_clk,
  input  wire logic                   i_arst_n,
  // operating mode and standby
  input  wire logic [`DIO_MODE_W-1:0] i_mode,
  input  wire logic                   i_hw_standby,
  input  wire logic                   i_sw_standby,
  // register port
  input  wire logic [`DIO_ADDR_W-1:0] i_addr,
  input  wire logic [7:0]             i_wdata,
  input  wire logic                   i_wr,
  input  wire logic                   i_rd,
  output logic      [7:0]             o_rdata,
  // first port pins
  input  wire logic [7:0]             i_two_pin,
  output logic      [7:0]             o_two_pin,
  output logic      [7:0]             o_two_oe,
  output logic      [7:0]             o_two_addr_sel,
  output logic      [7:0]             o_two_pullup,
  input  wire logic [7:0]             i_addr_bus,
  // second port pins
  input  wire logic [7:0]             i_eight_pin,
  output logic      [7:0]             o_eight_pin,
  output logic      [7:0]             o_eight_oe
);
  ////////////////////////////////////////////////////////////////////////////
  // reset synchroniser
  logic rst_meta_q;
  logic rst_n_q;
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mode decode
  dio_mode_grp_t grp;
  always_comb begin
    case (i_mode)
      3'd1, 3'd2, 3'd3, 3'd4: grp = DIO_GRP_EXP_NOROM;
      3'd5:                   grp = DIO_GRP_EXP_ROM;
      3'd6, 3'd7:             grp = DIO_GRP_SINGLE;
      default:                grp = DIO_GRP_INVALID;
    endcase
  end
  logic exp_norom;
  assign exp_norom = (grp == DIO_GRP_EXP_NOROM);

  // hardware standby acts like reset; reset values follow the mode
  logic rst_pend_q;
  logic init;
  assign init = i_hw_standby || !rst_pend_q;
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_pend_q <= 1'b0;
    end else begin
      rst_pend_q <= rst_n_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write decode
  logic wr_two_dir;
  logic wr_two_latch;
  logic wr_two_pullup;
  logic wr_eight_dir;
  logic wr_eight_latch;
  assign wr_two_dir     = i_wr && (i_addr == `DIO_OFF_TWO_DIR);
  assign wr_two_latch   = i_wr && (i_addr == `DIO_OFF_TWO_LATCH);
  assign wr_two_pullup  = i_wr && (i_addr == `DIO_OFF_TWO_PULLUP);
  assign wr_eight_dir   = i_wr && (i_addr == `DIO_OFF_EIGHT_DIR);
  assign wr_eight_latch = i_wr && (i_addr == `DIO_OFF_EIGHT_LATCH);

  ////////////////////////////////////////////////////////////////////////////
  // first port registers
  logic [7:0] two_dir_q;
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      two_dir_q <= `DIO_RST_TWO_DIR_SC;
    end else if (init) begin
      two_dir_q <= exp_norom ? `DIO_RST_TWO_DIR_EXP : `DIO_RST_TWO_DIR_SC;
    end else if (exp_norom) begin
      two_dir_q <= `DIO_ALL_ONES;
    end else if (wr_two_dir) begin
      two_dir_q <= i_wdata;
    end
  end

  logic [7:0] two_latch_q;
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      two_latch_q <= `DIO_RST_TWO_LATCH;
    end else if (init) begin
      two_latch_q <= `DIO_RST_TWO_LATCH;
    end else if (wr_two_latch) begin
      two_latch_q <= i_wdata;
    end
  end

  logic [7:0] two_pullup_q;
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      two_pullup_q <= `DIO_RST_TWO_PULLUP;
    end else if (init) begin
      two_pullup_q <= `DIO_RST_TWO_PULLUP;
    end else if (wr_two_pullup) begin
      two_pullup_q <= i_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // second port registers; software standby simply leaves them alone
  logic [7:0] eight_dir_q;
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      eight_dir_q <= `DIO_RST_EIGHT_DIR_SC;
    end else if (init) begin
      eight_dir_q <= exp_norom ? `DIO_RST_EIGHT_DIR_EXP : `DIO_RST_EIGHT_DIR_SC;
    end else if (wr_eight_dir && !i_sw_standby) begin
      eight_dir_q <= i_wdata;
    end
  end

  logic [7:0] eight_latch_q;
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      eight_latch_q <= `DIO_RST_EIGHT_LATCH;
    end else if (init) begin
      eight_latch_q <= `DIO_RST_EIGHT_LATCH;
    end else if (wr_eight_latch && !i_sw_standby) begin
      eight_latch_q <= (i_wdata & ~`DIO_EIGHT_RSV_MASK) | `DIO_EIGHT_RSV_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drive
  logic [7:0] two_addr_sel;
  logic [7:0] two_gp_oe;
  always_comb begin
    case (grp)
      DIO_GRP_EXP_NOROM: begin
        two_addr_sel = `DIO_ALL_ONES;
        two_gp_oe    = 8'h00;
      end
      DIO_GRP_EXP_ROM: begin
        two_addr_sel = two_dir_q;
        two_gp_oe    = 8'h00;
      end
      DIO_GRP_SINGLE: begin
        two_addr_sel = 8'h00;
        two_gp_oe    = two_dir_q;
      end
      default: begin
        two_addr_sel = 8'h00;
        two_gp_oe    = 8'h00;
      end
    endcase
  end

  assign o_two_addr_sel = two_addr_sel;
  assign o_two_oe       = two_addr_sel | two_gp_oe;
  assign o_two_pin      = (two_addr_sel & i_addr_bus) | (~two_addr_sel & two_latch_q);
  assign o_two_pullup   = two_pullup_q;
  assign o_eight_oe     = (grp == DIO_GRP_SINGLE) ? eight_dir_q : 8'h00;
  assign o_eight_pin    = eight_latch_q;

  ////////////////////////////////////////////////////////////////////////////
  // read path, one cycle latency
  logic [7:0] rdata_d;
  logic [7:0] rdata_q;
  always_comb begin
    rdata_d = 8'h00;
    if (i_rd) begin
      case (i_addr)
        `DIO_OFF_TWO_DIR:     rdata_d = `DIO_ALL_ONES;
        `DIO_OFF_TWO_LATCH:   rdata_d = two_latch_q;
        `DIO_OFF_TWO_PULLUP:  rdata_d = two_pullup_q;
        `DIO_OFF_EIGHT_DIR:   rdata_d = `DIO_ALL_ONES;
        `DIO_OFF_EIGHT_LATCH: rdata_d = ((eight_dir_q & eight_latch_q)
                                        | (~eight_dir_q & i_eight_pin))
                                        | `DIO_EIGHT_RSV_MASK;
        default:              rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end
  assign o_rdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  a_two_dir_forced: assert property (@(posedge i_clk) disable iff (!rst_n_q)
    exp_norom && !init |=> two_dir_q == `DIO_ALL_ONES)
    else $error("first direction not forced to ones");
  a_two_dir_read: assert property (@(posedge i_clk) disable iff (!rst_n_q)
    i_rd && i_addr == `DIO_OFF_TWO_DIR |=> o_rdata == `DIO_ALL_ONES)
    else $error("first direction read not all ones");
  a_eight_dir_read: assert property (@(posedge i_clk) disable iff (!rst_n_q)
    i_rd && i_addr == `DIO_OFF_EIGHT_DIR |=> o_rdata == `DIO_ALL_ONES)
    else $error("second direction read not all ones");
  a_eight_rsv_ones: assert property (@(posedge i_clk) disable iff (!rst_n_q)
    (eight_latch_q & `DIO_EIGHT_RSV_MASK) == `DIO_EIGHT_RSV_MASK)
    else $error("second latch reserved bits not one");
  a_eight_read_mix: assert property (@(posedge i_clk) disable iff (!rst_n_q)
    i_rd && i_addr == `DIO_OFF_EIGHT_LATCH && !init |=> (o_rdata & $past(eight_dir_q))
      == ($past(eight_latch_q) & $past(eight_dir_q)))
    else $error("second read ignores latch for outputs");
  a_two_latch_wr: assert property (@(posedge i_clk) disable iff (!rst_n_q)
    wr_two_latch && !init |=> two_latch_q == $past(i_wdata))
    else $error("first latch write lost");
  a_pullup_wr: assert property (@(posedge i_clk) disable iff (!rst_n_q)
    wr_two_pullup && !init |=> o_two_pullup == $past(i_wdata))
    else $error("pull-up write lost");
  a_eight_standby: assert property (@(posedge i_clk) disable iff (!rst_n_q)
    i_sw_standby && !i_hw_standby && rst_pend_q |=> $stable(eight_dir_q)
      && $stable(eight_latch_q))
    else $error("second port changed in software standby");
  a_single_oe: assert property (@(posedge i_clk) disable iff (!rst_n_q)
    grp == DIO_GRP_SINGLE |-> o_two_oe == two_dir_q && o_eight_oe == eight_dir_q)
    else $error("single chip output enable mismatch");
  a_mode5_addr: assert property (@(posedge i_clk) disable iff (!rst_n_q)
    grp == DIO_GRP_EXP_ROM |-> o_two_addr_sel == two_dir_q)
    else $error("mode five address select mismatch");

  ////////////////////////////////////////////////////////////////////////////
  // first port direction checks
  a_two_dir_init: assert property (@(posedge i_clk) disable iff (!rst_n_q)
    init && exp_norom |=> two_dir_q == `DIO_RST_TWO_DIR_EXP)
    else $error("first direction init value wrong in modes one to four");
  a_two_dir_init_sc: assert property (@(posedge i_clk) disable iff (!rst_n_q)
    init && !exp_norom |=> two_dir_q == `DIO_RST_TWO_DIR_SC)
    else $error("first direction init value wrong in modes five to seven");
  a_two_dir_write: assert property (@(posedge i_clk) disable iff (!rst_n_q)
    wr_two_dir && !init && !exp_norom |=> two_dir_q == $past(i_wdata))
    else $error("first direction write lost");
  a_two_dir_keep: assert property (@(posedge i_clk) disable iff (!rst_n_q)
    wr_two_dir && !init && exp_norom |=> two_dir_q == `DIO_ALL_ONES)
    else $error("first direction write not ignored");
  a_two_dir_read_exp: assert property (@(posedge i_clk) disable iff (!rst_n_q)
    i_rd && i_addr == `DIO_OFF_TWO_DIR && exp_norom |=> o_rdata == `DIO_ALL_ONES)
    else $error("first direction read not ones in modes one to four");
  a_two_dir_read_sc: assert property (@(posedge i_clk) disable iff (!rst_n_q)
    i_rd && i_addr == `DIO_OFF_TWO_DIR && !exp_norom |=> o_rdata == `DIO_ALL_ONES)
    else $error("first direction read not ones in modes five to seven");

  ////////////////////////////////////////////////////////////////////////////
  // first port pin checks
  a_two_oe_exp: assert property (@(posedge i_clk) disable iff (!rst_n_q)
    grp == DIO_GRP_EXP_NOROM |-> o_two_oe == `DIO_ALL_ONES && o_two_addr_sel == `DIO_ALL_ONES)
    else $error("first port not all address outputs");
  a_two_addr_out: assert property (@(posedge i_clk) disable iff (!rst_n_q)
    exp_norom |-> o_two_pin == i_addr_bus)
    else $error("first port does not carry address");
  a_mode5_oe: assert property (@(posedge i_clk) disable iff (!rst_n_q)
    grp == DIO_GRP_EXP_ROM |-> o_two_oe == two_dir_q)
    else $error("mode five output enable mismatch");
  a_mode5_pin: assert property (@(posedge i_clk) disable iff (!rst_n_q)
    grp == DIO_GRP_EXP_ROM |-> (o_two_pin & two_dir_q) == (i_addr_bus & two_dir_q))
    else $error("mode five address pins not driven from address");
  a_two_gp_pin: assert property (@(posedge i_clk) disable iff (!rst_n_q)
    grp == DIO_GRP_SINGLE |-> o_two_pin == two_latch_q)
    else $error("first port output not from latch");
  a_two_sel_single: assert property (@(posedge i_clk) disable iff (!rst_n_q)
    grp == DIO_GRP_SINGLE |-> o_two_addr_sel == 8'h00)
    else $error("single chip first port carries address");

  ////////////////////////////////////////////////////////////////////////////
  // first port data and pull-up checks
  a_two_latch_init: assert property (@(posedge i_clk) disable iff (!rst_n_q)
    init |=> two_latch_q == `DIO_RST_TWO_LATCH)
    else $error("first latch init value wrong");
  a_two_latch_hold: assert property (@(posedge i_clk) disable iff (!rst_n_q)
    !wr_two_latch && !init |=> $stable(two_latch_q))
    else $error("first latch changed without write");
  a_two_latch_read: assert property (@(posedge i_clk) disable iff (!rst_n_q)
    i_rd && i_addr == `DIO_OFF_TWO_LATCH |=> o_rdata == $past(two_latch_q))
    else $error("first latch read mismatch");
  a_pullup_init: assert property (@(posedge i_clk) disable iff (!rst_n_q)
    init |=> o_two_pullup == `DIO_RST_TWO_PULLUP)
    else $error("pull-up init value wrong");
  a_pullup_hold: assert property (@(posedge i_clk) disable iff (!rst_n_q)
    !wr_two_pullup && !init |=> $stable(two_pullup_q))
    else $error("pull-up changed without write");
  a_pullup_read: assert property (@(posedge i_clk) disable iff (!rst_n_q)
    i_rd && i_addr == `DIO_OFF_TWO_PULLUP |=> o_rdata == $past(two_pullup_q))
    else $error("pull-up read mismatch");

  ////////////////////////////////////////////////////////////////////////////
  // second port checks
  a_eight_oe_single: assert property (@(posedge i_clk) disable iff (!rst_n_q)
    grp == DIO_GRP_SINGLE |-> o_eight_oe == eight_dir_q)
    else $error("second port enable not from direction");
  a_eight_oe_other: assert property (@(posedge i_clk) disable iff (!rst_n_q)
    grp != DIO_GRP_SINGLE |-> o_eight_oe == 8'h00)
    else $error("second port drives outside single chip mode");
  a_eight_dir_init: assert property (@(posedge i_clk) disable iff (!rst_n_q)
    init && exp_norom |=> eight_dir_q == `DIO_RST_EIGHT_DIR_EXP)
    else $error("second direction init wrong in modes one to four");
  a_eight_dir_init_sc: assert property (@(posedge i_clk) disable iff (!rst_n_q)
    init && !exp_norom |=> eight_dir_q == `DIO_RST_EIGHT_DIR_SC)
    else $error("second direction init wrong in modes five to seven");
  a_eight_dir_write: assert property (@(posedge i_clk) disable iff (!rst_n_q)
    wr_eight_dir && !i_sw_standby && !init |=> eight_dir_q == $past(i_wdata))
    else $error("second direction write lost");
  a_eight_dir_hold: assert property (@(posedge i_clk) disable iff (!rst_n_q)
    !wr_eight_dir && !init |=> $stable(eight_dir_q))
    else $error("second direction changed without write");
  a_eight_latch_write: assert property (@(posedge i_clk) disable iff (!rst_n_q)
    wr_eight_latch && !i_sw_standby && !init
      |=> eight_latch_q == ($past(i_wdata) | `DIO_EIGHT_RSV_MASK))
    else $error("second latch write lost");
  a_eight_latch_init: assert property (@(posedge i_clk) disable iff (!rst_n_q)
    init |=> eight_latch_q == `DIO_RST_EIGHT_LATCH)
    else $error("second latch init value wrong");
  a_eight_latch_hold: assert property (@(posedge i_clk) disable iff (!rst_n_q)
    !wr_eight_latch && !init |=> $stable(eight_latch_q))
    else $error("second latch changed without write");
  a_eight_sw_write: assert property (@(posedge i_clk) disable iff (!rst_n_q)
    i_sw_standby && wr_eight_latch && !init |=> $stable(eight_latch_q))
    else $error("second latch written in software standby");
  a_eight_read_pins: assert property (@(posedge i_clk) disable iff (!rst_n_q)
    i_rd && i_addr == `DIO_OFF_EIGHT_LATCH
      |=> (o_rdata & ~$past(eight_dir_q) & ~`DIO_EIGHT_RSV_MASK)
        == ($past(i_eight_pin) & ~$past(eight_dir_q) & ~`DIO_EIGHT_RSV_MASK))
    else $error("second read ignores pins for inputs");
  a_eight_read_rsv: assert property (@(posedge i_clk) disable iff (!rst_n_q)
    i_rd && i_addr == `DIO_OFF_EIGHT_LATCH
      |=> (o_rdata & `DIO_EIGHT_RSV_MASK) == `DIO_EIGHT_RSV_MASK)
    else $error("second read reserved bits not one");
  c_two_write: cover property (@(posedge i_clk) disable iff (!rst_n_q) wr_two_latch);
  c_eight_read: cover property (@(posedge i_clk) disable iff (!rst_n_q)
    i_rd && i_addr == `DIO_OFF_EIGHT_LATCH);
  c_sw_standby: cover property (@(posedge i_clk) disable iff (!rst_n_q)
    i_sw_standby && wr_eight_dir);
  c_hw_standby: cover property (@(posedge i_clk) disable iff (!rst_n_q) i_hw_standby);
endmodule

/* dio_pins.sv */
// board model that resolves the pin levels of both ports
`timescale 1ns/1ns
module dio_pins (
  // design drive
  input  wire logic [7:0] i_two_pin,
  input  wire logic [7:0] i_two_oe,
  input  wire logic [7:0] i_two_pullup,
  input  wire logic [7:0] i_eight_pin,
  input  wire logic [7:0] i_eight_oe,
  // board drive on pins left free
  input  wire logic [7:0] i_board,
  // resolved levels
  output logic      [7:0] o_two_lvl,
  output logic      [7:0] o_eight_lvl
);
  // driven pins follow the design, pulled-up pins go high, others follow the board
  assign o_two_lvl   = (i_two_oe & i_two_pin) | (~i_two_oe & (i_two_pullup | i_board));
  assign o_eight_lvl = (i_eight_oe & i_eight_pin) | (~i_eight_oe & i_board);
endmodule

/* testbench.sv */
// self-checking bench for the dual port block
`timescale 1ns/1ns
`include "dio_consts.svh"
module testbench;
  import dio_pkg::*;
  logic                   clk, arst_n, hw_sb, sw_sb, wr, rd;
  logic [`DIO_MODE_W-1:0] mode;
  logic [`DIO_ADDR_W-1:0] addr;
  logic [7:0]             wdata, rdata, board, abus, two_lvl, two_pin, two_oe, two_sel;
  logic [7:0]             two_pu, eight_lvl, eight_pin, eight_oe;
  int                     error_cnt = 0;
  int                     cmp_count = 0;

  dio_port i_dut (.i_clk(clk), .i_arst_n(arst_n), .i_mode(mode), .i_hw_standby(hw_sb),
    .i_sw_standby(sw_sb), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .i_two_pin(two_lvl), .o_two_pin(two_pin), .o_two_oe(two_oe),
    .o_two_addr_sel(two_sel), .o_two_pullup(two_pu), .i_addr_bus(abus),
    .i_eight_pin(eight_lvl), .o_eight_pin(eight_pin), .o_eight_oe(eight_oe));
  dio_pins i_pins (.i_two_pin(two_pin), .i_two_oe(two_oe), .i_two_pullup(two_pu),
    .i_eight_pin(eight_pin), .i_eight_oe(eight_oe), .i_board(board),
    .o_two_lvl(two_lvl), .o_eight_lvl(eight_lvl));

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic end_of_test;
    $display("comparisons %0d errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr8(input logic [`DIO_ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask

  task automatic rd8(input logic [`DIO_ADDR_W-1:0] a, input logic [7:0] exp, input string n);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(n, exp, rdata);
  endtask

  task automatic do_reset(input logic [`DIO_MODE_W-1:0] m);
    @(posedge clk);
    arst_n <= 1'b0;
    mode   <= m;
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #1000000;
    error_cnt++;
    end_of_test();
  end

  initial begin
    arst_n = 1'b0;
    hw_sb  = 1'b0;
    sw_sb  = 1'b0;
    wr     = 1'b0;
    rd     = 1'b0;
    mode   = 3'h6;
    addr   = 20'h00000;
    wdata  = 8'h00;
    board  = 8'h1a;
    abus   = 8'h96;
    // single-chip mode
    do_reset(3'h6);
    rd8(`DIO_OFF_TWO_DIR, 8'hff, "two dir read");
    wr8(`DIO_OFF_TWO_DIR, 8'h0f);
    chk("two oe", 8'h0f, two_oe);
    chk("two addr sel", 8'h00, two_sel);
    rd8(`DIO_OFF_TWO_DIR, 8'hff, "two dir read");
    rd8(`DIO_OFF_TWO_LATCH, 8'h00, "two latch");
    wr8(`DIO_OFF_TWO_LATCH, 8'ha5);
    rd8(`DIO_OFF_TWO_LATCH, 8'ha5, "two latch");
    chk("two level", 8'h15, two_lvl);
    rd8(`DIO_OFF_TWO_PULLUP, 8'h00, "pullup");
    wr8(`DIO_OFF_TWO_PULLUP, 8'h3c);
    rd8(`DIO_OFF_TWO_PULLUP, 8'h3c, "pullup");
    chk("two pullup", 8'h3c, two_pu);
    rd8(`DIO_OFF_EIGHT_DIR, 8'hff, "eight dir read");
    chk("eight oe", 8'he0, eight_oe);
    rd8(`DIO_OFF_EIGHT_LATCH, 8'hfa, "eight port");
    wr8(`DIO_OFF_EIGHT_LATCH, 8'h15);
    chk("eight pin", 8'hf5, eight_pin);
    wr8(`DIO_OFF_EIGHT_DIR, 8'h0f);
    chk("eight oe", 8'h0f, eight_oe);
    board = 8'ha0;
    rd8(`DIO_OFF_EIGHT_LATCH, 8'he5, "eight port");
    // software standby keeps the second port
    @(posedge clk);
    sw_sb <= 1'b1;
    wr8(`DIO_OFF_EIGHT_DIR, 8'h00);
    wr8(`DIO_OFF_EIGHT_LATCH, 8'h00);
    chk("eight oe", 8'h0f, eight_oe);
    chk("eight pin", 8'hf5, eight_pin);
    @(posedge clk);
    sw_sb <= 1'b0;
    rd8(20'h00000, 8'h00, "unmapped");
    // hardware standby re-initialises
    @(posedge clk);
    hw_sb <= 1'b1;
    repeat (2) @(posedge clk);
    hw_sb <= 1'b0;
    @(posedge clk);
    #1;
    chk("eight oe", 8'he0, eight_oe);
    chk("eight pin", 8'he0, eight_pin);
    // expanded mode with rom
    do_reset(3'h5);
    chk("two oe", 8'h00, two_oe);
    chk("two pullup", 8'h00, two_pu);
    wr8(`DIO_OFF_TWO_DIR, 8'h33);
    chk("two addr sel", 8'h33, two_sel);
    chk("two addr out", 8'h12, two_pin & 8'h33);
    // expanded mode without rom
    do_reset(3'h2);
    board = 8'h5a;
    rd8(`DIO_OFF_TWO_DIR, 8'hff, "two dir read");
    chk("two oe", 8'hff, two_oe);
    chk("two addr sel", 8'hff, two_sel);
    chk("two addr out", 8'h96, two_pin);
    wr8(`DIO_OFF_TWO_DIR, 8'h00);
    chk("two addr sel", 8'hff, two_sel);
    rd8(`DIO_OFF_EIGHT_LATCH, 8'hea, "eight port");
    end_of_test();
  end
endmodule
